// ==== rtl/lcf_cluster.sv ====
// logic cluster of ten cells with look-up, register and carry logic
// assumes routing inputs are on ref_clk_i; column clocks arrive from pins
//
// Functional notes
// - ten cells, chains, control, local interconnect
// - twenty-six external inputs plus ten feedback lines
// - look-up output cascades to next cell
// - register output cascades to next register
// - cell output reaches thirty cells via neighbours
// - ten cluster control lines at most
// - each clock paired with own enable
// - each cluster clock acts on one chosen edge, rising or falling
// - disabled enable stops the cluster clock
// - preset by inversion, else load high
// - controls from column clocks and local lines
// - four-input look-up, register, carry per cell
// - register acts as D, T, JK, SR
// - asynchronous load data from fourth input
// - combinational use bypasses the register
// - three outputs, each look-up or register
// - register may feed own look-up
// - add/subtract select shared by all cells
// - subtract inverts B, carry-in one
// - first cell gets carry-in one subtracting
// - clear beats preset/load, register goes low
// - registers start low unless configured high
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module lcf_cluster (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic [3:0] col_clk_i,
   input wire logic [25:0] ext_in_i,
   input wire logic [9:0] left_in_i,
   input wire logic [9:0] right_in_i,
   input wire logic lut_chain_i,
   input wire logic reg_chain_i,
   input wire logic carry_in_i,
   output logic [9:0] route_a_o,
   output logic [9:0] route_b_o,
   output logic lut_chain_o,
   output logic reg_chain_o,
   output logic carry_out_o
);
   localparam int N = lcf_pkg::NCELL;

   logic [31:0] cfg_r [0:2*N-1];
   logic [31:0] ctl0_r;
   logic [31:0] ctl1_r;
   logic [31:0] ctl2_r;
   logic start_r;
   logic [N-1:0] fb_r;
   logic [N-1:0] q;
   logic [N-1:0] lut_out;
   logic [N-1:0] cout;
   logic [lcf_pkg::NLINE-1:0] line;
   logic [lcf_pkg::NGCLK-1:0] gs1_r;
   logic [lcf_pkg::NGCLK-1:0] gs2_r;
   logic [lcf_pkg::NGCLK-1:0] gs3_r;
   logic [lcf_pkg::NGCLK-1:0] gclk_r;
   logic [1:0] clk_val;
   logic [1:0] clk_prev_r;
   lcf_pkg::lcf_ctl_type ctl;
   logic run;

   function automatic logic pick(input logic [lcf_pkg::NLINE-1:0] bus, input logic [5:0] sel);
      pick = (sel < 6'(lcf_pkg::NLINE)) ? bus[sel] : 1'b0;
   endfunction

   assign run = ctl0_r[lcf_pkg::C0_RUN];

   // configuration port
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int k = 0; k < 2*N; k++) begin
            cfg_r[k] <= lcf_pkg::CFG_RESET;
         end
      end else if (reg_wr_i && reg_addr_i <= lcf_pkg::IDX_CELL_LAST) begin
         cfg_r[reg_addr_i] <= reg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl0_r <= lcf_pkg::CTL_RESET;
         ctl1_r <= lcf_pkg::CTL_RESET;
         ctl2_r <= lcf_pkg::CTL_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == lcf_pkg::IDX_CTL0) begin
            ctl0_r <= reg_wdata_i;
         end
         if (reg_addr_i == lcf_pkg::IDX_CTL1) begin
            ctl1_r <= reg_wdata_i;
         end
         if (reg_addr_i == lcf_pkg::IDX_CTL2) begin
            ctl2_r <= reg_wdata_i;
         end
      end
   end

   // one-cycle start pulse when run goes from 0 to 1: registers take power-up state
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_r <= 1'b0;
      end else begin
         start_r <= reg_wr_i && reg_addr_i == lcf_pkg::IDX_CTL0 && reg_wdata_i[lcf_pkg::C0_RUN] && !run;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         if (reg_addr_i <= lcf_pkg::IDX_CELL_LAST) begin
            reg_rdata_o <= cfg_r[reg_addr_i];
         end else if (reg_addr_i == lcf_pkg::IDX_CTL0) begin
            reg_rdata_o <= ctl0_r;
         end else if (reg_addr_i == lcf_pkg::IDX_CTL1) begin
            reg_rdata_o <= ctl1_r;
         end else if (reg_addr_i == lcf_pkg::IDX_CTL2) begin
            reg_rdata_o <= ctl2_r;
         end else if (reg_addr_i == lcf_pkg::IDX_STATUS) begin
            reg_rdata_o <= 32'h00000000;
            reg_rdata_o[lcf_pkg::ST_Q +: N] <= q;
            reg_rdata_o[lcf_pkg::ST_GCLK +: lcf_pkg::NGCLK] <= gclk_r;
            reg_rdata_o[lcf_pkg::ST_RUN] <= run;
         end else begin
            reg_rdata_o <= 32'h00000000;
         end
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

   // column clocks come from pins: three flops, accepted once stages two and three agree
   generate
      for (genvar g = 0; g < lcf_pkg::NGCLK; g++) begin : g_gclk
         always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               gs1_r[g] <= 1'b0;
               gs2_r[g] <= 1'b0;
               gs3_r[g] <= 1'b0;
               gclk_r[g] <= 1'b0;
            end else begin
               gs1_r[g] <= col_clk_i[g];
               gs2_r[g] <= gs1_r[g];
               gs3_r[g] <= gs2_r[g];
               if (gs2_r[g] == gs3_r[g]) begin
                  gclk_r[g] <= gs3_r[g];
               end
            end
         end
      end
   endgenerate

   // local interconnect: constants, external, own feedback, left and right neighbours
   assign line = {right_in_i, left_in_i, fb_r, ext_in_i, 1'b1, 1'b0};

   // cluster clocks from a column clock or a local line, each with its own edge
   always_comb begin
      clk_val[0] = ctl0_r[lcf_pkg::C0_CLK0_LOC] ? pick(line, ctl0_r[lcf_pkg::C0_CLK0_SEL +: 6])
                                                : gclk_r[ctl0_r[lcf_pkg::C0_CLK0_G +: 2]];
      clk_val[1] = ctl0_r[lcf_pkg::C0_CLK1_LOC] ? pick(line, ctl0_r[lcf_pkg::C0_CLK1_SEL +: 6])
                                                : gclk_r[ctl0_r[lcf_pkg::C0_CLK1_G +: 2]];
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clk_prev_r <= 2'h0;
      end else begin
         clk_prev_r <= clk_val;
      end
   end

   // the ten control lines; a falling-edge user must take the clock set to fall
   always_comb begin
      ctl.clk_ev[0] = ctl0_r[lcf_pkg::C0_CLK0_FALL] ? (clk_prev_r[0] && !clk_val[0])
                                                    : (!clk_prev_r[0] && clk_val[0]);
      ctl.clk_ev[1] = ctl0_r[lcf_pkg::C0_CLK1_FALL] ? (clk_prev_r[1] && !clk_val[1])
                                                    : (!clk_prev_r[1] && clk_val[1]);
      ctl.ena[0] = pick(line, ctl0_r[lcf_pkg::C0_ENA0 +: 6]);
      ctl.ena[1] = pick(line, ctl1_r[lcf_pkg::C1_ENA1 +: 6]);
      ctl.aclr[0] = pick(line, ctl1_r[lcf_pkg::C1_ACLR0 +: 6]);
      ctl.aclr[1] = pick(line, ctl1_r[lcf_pkg::C1_ACLR1 +: 6]);
      ctl.sclr = pick(line, ctl1_r[lcf_pkg::C1_SCLR +: 6]);
      ctl.sload = pick(line, ctl1_r[lcf_pkg::C1_SLOAD +: 6]);
      ctl.aload = pick(line, ctl2_r[lcf_pkg::C2_ALOAD +: 6]);
      ctl.add = pick(line, ctl2_r[lcf_pkg::C2_ADDSUB +: 6]);
   end

   generate
      for (genvar c = 0; c < N; c++) begin : g_cell
         lcf_pkg::lcf_cell_cfg_type cfg;
         logic d0, d1, d2, d3, i2, i3;
         logic b_eff, cin, lut_prev, q_prev;
         logic inv, pushback, rdat, tick, q_nxt, upd;
         logic s_r;

         assign cfg = {cfg_r[2*c+1], cfg_r[2*c]};
         assign lut_prev = (c == 0) ? lut_chain_i : lut_out[(c == 0) ? 0 : c-1];
         assign q_prev = (c == 0) ? reg_chain_i : q[(c == 0) ? 0 : c-1];

         always_comb begin
            d0 = pick(line, cfg.sel0);
            d1 = pick(line, cfg.sel1);
            d2 = pick(line, cfg.sel2);
            d3 = pick(line, cfg.sel3);
            i2 = cfg.lut_chain_in ? lut_prev : d2;
            i3 = cfg.pack_fb ? q[c] : d3;
            b_eff = d1 ^ !ctl.add;
            if (cfg.chain_start || c == 0) begin
               cin = (c == 0 && !cfg.chain_start) ? (carry_in_i | !ctl.add) : !ctl.add;
            end else begin
               cin = cout[(c == 0) ? 0 : c-1];
            end
            cout[c] = (d0 & b_eff) | (cin & (d0 ^ b_eff));
            if (cfg.arith) begin
               lut_out[c] = d0 ^ b_eff ^ cin;
            end else begin
               lut_out[c] = cfg.lut[{i3, i2, d1, d0}];
            end
         end

         // preset by stored inversion unless it is off or the register starts high
         assign pushback = cfg.preset_en && !cfg.no_pushback && !cfg.pwr_high;
         assign inv = pushback;
         assign q[c] = s_r ^ inv;
         assign rdat = cfg.reg_chain_in ? q_prev : lut_out[c];
         assign tick = ctl.clk_ev[cfg.clk_sel] && ctl.ena[cfg.clk_sel];

         always_comb begin
            q_nxt = q[c];
            upd = 1'b1;
            if (ctl.aclr[cfg.aclr_sel]) begin
               q_nxt = 1'b0;
            end else if (ctl.aload) begin
               q_nxt = (pushback || cfg.preset_en) ? 1'b1 : d3;
            end else if (tick) begin
               if (cfg.sync_ctl_en && ctl.sclr) begin
                  q_nxt = 1'b0;
               end else if (cfg.sync_ctl_en && ctl.sload) begin
                  q_nxt = d3;
               end else begin
                  case (cfg.ff_mode)
                     lcf_pkg::LCF_FF_D: q_nxt = rdat;
                     lcf_pkg::LCF_FF_T: q_nxt = q[c] ^ rdat;
                     lcf_pkg::LCF_FF_JK: q_nxt = (rdat && !q[c]) || (!d1 && q[c]);
                     lcf_pkg::LCF_FF_SR: q_nxt = rdat || (!d1 && q[c]);
                     default: q_nxt = q[c];
                  endcase
               end
            end else begin
               upd = 1'b0;
            end
         end

         // asynchronous clears act in the next system cycle, not waiting for a cluster clock edge
         always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               s_r <= 1'b0;
            end else if (start_r) begin
               s_r <= cfg.pwr_high ^ inv;
            end else if (run && upd) begin
               s_r <= q_nxt ^ inv;
            end
         end

         // three outputs, each picks look-up or register
         always_ff @(posedge ref_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               route_a_o[c] <= 1'b0;
               route_b_o[c] <= 1'b0;
               fb_r[c] <= 1'b0;
            end else begin
               route_a_o[c] <= cfg.out_sel[0] ? q[c] : lut_out[c];
               route_b_o[c] <= cfg.out_sel[1] ? q[c] : lut_out[c];
               fb_r[c] <= cfg.out_sel[2] ? q[c] : lut_out[c];
            end
         end
      end
   endgenerate

   // cascades leave the cluster registered so the next cluster sees a clean value
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lut_chain_o <= 1'b0;
         reg_chain_o <= 1'b0;
         carry_out_o <= 1'b0;
      end else begin
         lut_chain_o <= lut_out[N-1];
         reg_chain_o <= q[N-1];
         carry_out_o <= cout[N-1];
      end
   end
endmodule

// ==== rtl/lcf_pkg.sv ====
// constants, configuration layout and carriers for the ten-cell logic cluster
// assumes a single 10 MHz system clock and a word-indexed configuration port
package lcf_pkg;
   localparam int NCELL = 10;
   localparam int NEXT = 26;
   localparam int NGCLK = 4;
   localparam int NLINE = 58;
   localparam int DW = 32;
   localparam int AW = 5;
   // local interconnect line numbers: constants, external, feedback, left, right
   localparam logic [5:0] LINE_ZERO = 6'h00;
   localparam logic [5:0] LINE_ONE = 6'h01;
   localparam int LINE_EXT = 2;
   localparam int LINE_FB = 28;
   localparam int LINE_LEFT = 38;
   localparam int LINE_RIGHT = 48;
   // word indices on the configuration port
   localparam logic [4:0] IDX_CELL_LAST = 5'h13;
   localparam logic [4:0] IDX_CTL0 = 5'h14;
   localparam logic [4:0] IDX_CTL1 = 5'h15;
   localparam logic [4:0] IDX_CTL2 = 5'h16;
   localparam logic [4:0] IDX_STATUS = 5'h17;
   localparam logic [31:0] CFG_RESET = 32'h00000000;
   localparam logic [31:0] CTL_RESET = 32'h00000000;
   // control word 0 fields
   localparam int C0_CLK0_G = 0;
   localparam int C0_CLK0_LOC = 2;
   localparam int C0_CLK0_FALL = 3;
   localparam int C0_CLK1_G = 4;
   localparam int C0_CLK1_LOC = 6;
   localparam int C0_CLK1_FALL = 7;
   localparam int C0_CLK0_SEL = 8;
   localparam int C0_CLK1_SEL = 14;
   localparam int C0_ENA0 = 20;
   localparam int C0_RUN = 31;
   // control word 1 and 2 fields
   localparam int C1_ENA1 = 0;
   localparam int C1_ACLR0 = 6;
   localparam int C1_ACLR1 = 12;
   localparam int C1_SCLR = 18;
   localparam int C1_SLOAD = 24;
   localparam int C2_ALOAD = 0;
   localparam int C2_ADDSUB = 6;
   // status word fields
   localparam int ST_Q = 0;
   localparam int ST_GCLK = 10;
   localparam int ST_RUN = 31;

   typedef enum logic [1:0] {
      LCF_FF_D,
      LCF_FF_T,
      LCF_FF_JK,
      LCF_FF_SR
   } lcf_ff_mode_type;

   // two configuration words per cell, odd word in the upper half
   typedef struct packed {
      logic [7:0] pad;
      logic aclr_sel;
      logic sync_ctl_en;
      logic pwr_high;
      logic no_pushback;
      logic preset_en;
      logic chain_start;
      logic reg_chain_in;
      logic lut_chain_in;
      logic pack_fb;
      logic [2:0] out_sel;
      logic [5:0] sel3;
      logic [5:0] sel2;
      logic arith;
      logic clk_sel;
      lcf_ff_mode_type ff_mode;
      logic [5:0] sel1;
      logic [5:0] sel0;
      logic [15:0] lut;
   } lcf_cell_cfg_type;

   // cluster-wide control lines, exactly ten
   typedef struct packed {
      logic [1:0] clk_ev;
      logic [1:0] ena;
      logic [1:0] aclr;
      logic sclr;
      logic aload;
      logic sload;
      logic add;
   } lcf_ctl_type;
endpackage

// ==== tb/lcf_cluster_asserts.sv ====
// port checks for the logic cluster register port and routing outputs
// assumes the single ref_clk_i domain with nrst_i as asynchronous reset
`timescale 1ns/10ps
module lcf_cluster_asserts (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [9:0] route_a_o,
   input wire logic [9:0] route_b_o,
   input wire logic lut_chain_o,
   input wire logic reg_chain_o,
   input wire logic carry_out_o
);
   logic wrote_r;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // control words are only known to be zero until the first write
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) wrote_r <= 1'b0;
      else if (reg_wr_i) wrote_r <= 1'b1;
   end
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside answer cycle");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 5'h17 |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_first_quiet: assert property ($rose(nrst_i) |->
      {route_a_o, route_b_o, lut_chain_o, reg_chain_o, carry_out_o} == 23'h0) else $error("outputs not low");
   a_ctl_reset: assert property (!wrote_r && reg_rd_i && reg_addr_i inside {[5'h14:5'h16]} |=>
      reg_rdata_o == 32'h0) else $error("control word not zero after reset");
   a_cfg_readback: assert property (reg_wr_i && reg_addr_i < 5'h14 && !reg_addr_i[0] ##1
      reg_rd_i && reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("cell word not read back");
   a_ctl2_readback: assert property (reg_wr_i && reg_addr_i == lcf_pkg::IDX_CTL2 ##1
      reg_rd_i && reg_addr_i == lcf_pkg::IDX_CTL2 |=> ((reg_rdata_o ^ $past(reg_wdata_i, 2)) & 32'hFFF) == 32'h0)
      else $error("control word 2 not read back");
   a_run_status: assert property (reg_wr_i && reg_addr_i == lcf_pkg::IDX_CTL0 && reg_wdata_i[31] ##1
      reg_rd_i && reg_addr_i == lcf_pkg::IDX_STATUS |=> reg_rdata_o[31]) else $error("run flag not seen");
   a_chain_status: assert property (reg_rd_i && reg_addr_i == lcf_pkg::IDX_STATUS |=>
      reg_rdata_o[9] == reg_chain_o) else $error("register chain out differs from last cell");
endmodule
bind lcf_cluster lcf_cluster_asserts u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .route_a_o(route_a_o), .route_b_o(route_b_o), .lut_chain_o(lut_chain_o), .reg_chain_o(reg_chain_o),
   .carry_out_o(carry_out_o));

// ==== tb/lcf_cluster_tb_top.sv ====
// self-checking bench for the ten-cell logic cluster
// assumes the neighbour model drives column clock 0 and the side-neighbour lines
`timescale 1ns/10ps
module lcf_cluster_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cin = 1'b0, rchain = 1'b0, pulse = 1'b0, lchain = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [25:0] ext = 26'h0000000;
   logic [31:0] wdata = 32'h0, rdata, q, d;
   logic [9:0] ra, rb, left, right, bits;
   logic [3:0] col;
   logic lco, rco, cout, busy, prev;
   int error_cnt = 0, samples_checked = 0, seed = 25, i, k, r;
   lcf_cluster dut (.ref_clk_i(clk), .nrst_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .col_clk_i(col), .ext_in_i(ext), .left_in_i(left), .right_in_i(right),
      .lut_chain_i(lchain), .reg_chain_i(rchain), .carry_in_i(cin), .route_a_o(ra), .route_b_o(rb),
      .lut_chain_o(lco), .reg_chain_o(rco), .carry_out_o(cout));
   lcf_nbr_model u_nbr (.ref_clk_i(clk), .nrst_i(rst_n), .pulse_i(pulse), .col_clk_o(col), .busy_o(busy),
      .left_o(left), .right_o(right));
   initial begin
      forever #50 clk = ~clk;
   end
   // q picks up the read answer of the previous cycle
   task automatic bus(input logic w, r, input logic [4:0] a, input logic [31:0] dv);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= dv;
      #1 q = rdata;
   endtask
   task automatic wrt(input logic [4:0] a, input logic [31:0] dv);
      bus(1'b1, 1'b0, a, dv);
      bus(1'b0, 1'b0, 5'h00, 32'h0);
   endtask
   task automatic rdt(input logic [4:0] a);
      bus(1'b0, 1'b1, a, 32'h0);
      bus(1'b0, 1'b0, 5'h00, 32'h0);
   endtask
   task automatic wrrd(input logic [4:0] a, input logic [31:0] dv, input logic [4:0] b);
      bus(1'b1, 1'b0, a, dv);
      rdt(b);
   endtask
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stat_chk(input logic [9:0] e);
      repeat (2) @(posedge clk);
      rdt(lcf_pkg::IDX_STATUS);
      chk(q & 32'h3FF, 32'(e));
   endtask
   task automatic clk_pulse(input logic b);
      @(posedge clk);
      rchain <= b;
      pulse <= 1'b1;
      @(posedge clk);
      pulse <= 1'b0;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         #1;
         if (busy !== 1'b1) break;
      end
   endtask
   function automatic logic [10:0] exp_sum(input logic [9:0] a, b, input logic c, add);
      return {1'b0, a} + {1'b0, add ? b : ~b} + {10'h000, c | !add};
   endfunction
   // next value of cell c after one tick of the second clock; cell 9 sits on the disabled first clock
   function automatic logic exp_ff(input int c, input logic qv, d0, d1, sc, sl);
      logic dat;
      dat = d0 ^ ((c > 3 && c < 8) ? qv : (c < 4));
      if (c == 9) return qv;
      if (c < 4 && sc) return 1'b0;
      if (c < 4 && sl) return 1'b1;
      case (c % 4)
         0: return dat;
         1: return qv ^ dat;
         2: return (dat && d1) ? !qv : dat ? 1'b1 : d1 ? 1'b0 : qv;
         default: return dat ? 1'b1 : d1 ? 1'b0 : qv;
      endcase
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 20; i < 23; i++) begin
         rdt(5'(i));
         chk(q, lcf_pkg::CTL_RESET);
      end
      wrt(lcf_pkg::IDX_STATUS, 32'hFFFFFFFF);
      stat_chk(10'h000);
      for (i = 0; i < 8; i++) begin
         wrrd(5'(24 + i), $random(seed), 5'(24 + i));
         chk(q, 32'h0);
      end
      for (i = 0; i < 10; i++) begin
         d = $random(seed);
         wrrd(5'(2 * i), d, 5'(2 * i));
         chk(q, d);
      end
      wrrd(lcf_pkg::IDX_CTL0, 32'h80000000, lcf_pkg::IDX_STATUS);
      chk(q & 32'h800003FF, 32'h80000000);
      // cell 0: look-up on route A, register on route B
      wrt(5'h01, 32'h00002000);
      for (i = 0; i < 8; i++) begin
         k = ($random(seed) & 32'h7FFFFFFF) % 26;
         wrt(5'h00, (i[0] ? 32'h00005555 : 32'h0000AAAA) | 32'((k + 2) << 16));
         ext <= 26'($random(seed));
         repeat (3) @(posedge clk);
         #1 chk(32'({rb[0], ra[0]}), 32'(ext[k] ^ i[0]));
      end
      wrt(5'h02, 32'h0026AAAA);
      wrt(5'h03, 32'h0);
      repeat (3) @(negedge clk);
      prev = left[0];
      for (i = 0; i < 8; i++) begin
         @(negedge clk);
         chk(32'(ra[1]), 32'(prev));
         prev = left[0];
      end
      for (i = 0; i < 10; i++) begin
         wrt(5'(2 * i), 32'h80000000 | 32'((12 + i) << 22) | 32'((2 + i) << 16));
         wrt(5'(2 * i + 1), 32'h0);
      end
      for (i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'h0 : (i == 1) ? 32'hC00007FF : $random(seed);
         wrrd(lcf_pkg::IDX_CTL2, d[30] ? 32'h40 : 32'h0, lcf_pkg::IDX_CTL2);
         ext <= d[25:0];
         cin <= d[31];
         repeat (3) @(posedge clk);
         #1 chk(32'({cout, ra}), 32'(exp_sum(d[9:0], d[19:10], d[31], d[30])));
      end
      // look-up chain: every cell passes its chained input, so all routes and the chain out follow it
      for (i = 0; i < 10; i++) begin
         wrt(5'(2 * i), 32'h0000F0F0);
         wrt(5'(2 * i + 1), 32'h00010000);
      end
      for (i = 0; i < 4; i++) begin
         lchain <= ~lchain;
         repeat (3) @(posedge clk);
         #1 chk(32'({lco, ra}), lchain ? 32'h000007FF : 32'h00000000);
      end
      // shift register on the register chain, route A shows the registers
      for (i = 0; i < 10; i++) begin
         wrt(5'(2 * i), 32'h0);
         wrt(5'(2 * i + 1), 32'h00021040);
      end
      wrt(lcf_pkg::IDX_CTL2, 32'h0);
      wrt(lcf_pkg::IDX_CTL0, 32'h80100000);
      bits = 10'($random(seed));
      for (i = 9; i >= 0; i--) clk_pulse(bits[i]);
      stat_chk(bits);
      chk(32'(ra), 32'(bits));
      wrt(lcf_pkg::IDX_CTL0, 32'h80000000);
      clk_pulse(~bits[0]);
      stat_chk(bits);
      wrt(lcf_pkg::IDX_CTL2, 32'h1);
      stat_chk(10'h3FF);
      wrt(lcf_pkg::IDX_CTL1, 32'h40);
      stat_chk(10'h000);
      wrt(lcf_pkg::IDX_CTL1, 32'h0);
      stat_chk(10'h3FF);
      // all four register types on the second clock, falling edge; cells 4 to 7 feed q back into the look-up
      wrt(lcf_pkg::IDX_CTL2, 32'h0);
      wrt(lcf_pkg::IDX_CTL0, 32'h80000080);
      for (i = 0; i < 10; i++) begin
         wrt(5'(2 * i), 32'h000055AA | 32'((i % 4) << 28) | ((i < 9) ? 32'h40000000 : 32'h0)
            | 32'((12 + i) << 22) | 32'((2 + i) << 16));
         wrt(5'(2 * i + 1), (i < 4) ? 32'h00400040 : (i < 8) ? 32'h00008000 : 32'h0);
      end
      bits = 10'h3FF;
      for (r = 0; r < 6; r++) begin
         d = $random(seed);
         wrt(lcf_pkg::IDX_CTL1, (r == 3) ? 32'h00040001 : (r == 4) ? 32'h01000001 : 32'h00000001);
         ext <= d[25:0];
         clk_pulse(1'b0);
         for (i = 0; i < 10; i++) bits[i] = exp_ff(i, bits[i], d[i], d[10 + i], r == 3, r == 4);
         stat_chk(bits);
      end
      // cell 9 starts high, cell 8 presets through its stored inversion
      wrt(5'h11, 32'h00080000);
      wrt(5'h13, 32'h00200000);
      wrt(lcf_pkg::IDX_CTL0, 32'h0);
      wrt(lcf_pkg::IDX_CTL0, 32'h80000000);
      stat_chk(10'h200);
      wrt(lcf_pkg::IDX_CTL2, 32'h1);
      stat_chk(10'h10F);
      complete_run;
   end
endmodule

// ==== tb/lcf_nbr_model.sv ====
// column clock source and side-neighbour clusters around the logic cluster
// assumes pulse_i is a one-cycle request on ref_clk_i, ignored while busy
`timescale 1ns/10ps
module lcf_nbr_model (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic pulse_i,
   output logic [3:0] col_clk_o,
   output logic busy_o,
   output logic [9:0] left_o,
   output logic [9:0] right_o
);
   logic [3:0] cnt_r;
   logic [9:0] lfsr_r;
   // six cycles high then six low, long enough for the three-stage sync to agree
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) cnt_r <= 4'h0;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
      else if (pulse_i) cnt_r <= 4'hC;
   end
   // neighbour lines change every cycle so a stale sample cannot pass
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) lfsr_r <= 10'h001;
      else lfsr_r <= {lfsr_r[8:0], lfsr_r[9] ^ lfsr_r[6]};
   end
   // column clock stands still between requested pulses
   assign col_clk_o = {3'h0, cnt_r > 4'h6};
   assign busy_o = cnt_r != 4'h0;
   assign left_o = lfsr_r;
   assign right_o = ~lfsr_r;
endmodule
